// >>> logic/dcocs_pkg.sv
package dcocs_pkg;

	localparam int DCOCS_DIV_W = 7;
	localparam int DCOCS_SLOT_W = 5;
	localparam int DCOCS_DAC_W = 8;
	localparam int DCOCS_SER_W = 20;
	localparam int DCOCS_ADDR_W = 2;
	localparam logic [1:0] DCOCS_ADDR_OFFCAL = 2'h3;
	localparam int DCOCS_FLD_DIV_LSB = 2;
	localparam int DCOCS_FLD_BIAS = 13;
	localparam int DCOCS_BUF_BITS = 3;
	localparam logic [6:0] DCOCS_DIV_RST = 7'h01;
	localparam logic DCOCS_BIAS_RST = 1'b0;
	localparam logic [7:0] DCOCS_DAC_MID = 8'h80;
	localparam logic [4:0] DCOCS_SLOT_SETTLE_END = 5'h07;
	localparam logic [4:0] DCOCS_SLOT_BAL_FIRST = 5'h08;
	localparam logic [4:0] DCOCS_SLOT_BAL_LAST = 5'h0A;
	localparam logic [4:0] DCOCS_SLOT_SRCH_FIRST = 5'h0D;
	localparam logic [4:0] DCOCS_SLOT_SRCH_LAST = 5'h15;
	localparam logic [4:0] DCOCS_SLOT_HOLD = 5'h16;

	typedef enum logic [1:0] {
		DCOCS_IDLE = 2'b00,
		DCOCS_RUN  = 2'b01,
		DCOCS_DONE = 2'b10
	} dcocs_state_t;

endpackage

// >>> logic/dcocs_sequencer.sv
// Summary of operation
// RQ1: Calibration clock is the reference divided by the programmed divider.
// RQ2: That clock is halved again; its period is one slot.
// RQ3: Only a rising edge of the trigger starts a calibration.
// RQ4: Slots 1 to 7 only let circuits settle.
// RQ5: Slots 8 to 10 auto-balance the comparators.
// RQ6: Slots 13 to 21 run the search, starting at about 400 mV step.
// RQ7: Comparator picks next step polarity; each step halves the last.
// RQ8: Slot 22 freezes the code until the next trigger edge.
// RQ9: In receive mode the AGC is off throughout calibration.
// RQ10: Eight-bit DAC code per channel, split between filter and buffer.
// RQ11: Per-channel comparator result drives the decision and register update.
// RQ12: Calibration runs in receive, transmit or power down mode.
// RQ13: A bit selects output common-mode bias via four resistors.
// RQ14: Quadrature LO comes from dividing the double-rate input by two.
// RQ15: Controller picks the divider for a 10 to 25 us calibration.
// RQ16: Divider is seven bits; total time 22 times twice divider per ref; cal_busy ends after 21 slots.
// RQ17: Settings load via 20-bit serial shift register; two LSBs address.
// RQ18: Slots 11 and 12 hold everything unchanged.
`timescale 1ns/1ps
`default_nettype none
module dcocs_sequencer
	import dcocs_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	input  wire logic                   ref_tick,
	input  wire logic                   cal_trigger,
	input  wire logic                   rx_mode,
	input  wire logic                   ser_clk_rise,
	input  wire logic                   ser_data,
	input  wire logic                   ser_load_rise,
	input  wire logic                   i_comp_pos,
	input  wire logic                   q_comp_pos,
	input  wire logic                   double_rate_osc_input,
	output logic [DCOCS_DAC_W-1:0]      i_offset_current_dac,
	output logic [DCOCS_DAC_W-1:0]      q_offset_current_dac,
	output logic [DCOCS_DAC_W-DCOCS_BUF_BITS-1:0] i_lpf_dac,
	output logic [DCOCS_BUF_BITS-1:0]   i_buf_dac,
	output logic [DCOCS_DAC_W-DCOCS_BUF_BITS-1:0] q_lpf_dac,
	output logic [DCOCS_BUF_BITS-1:0]   q_buf_dac,
	output logic                        comp_balance,
	output logic                        cal_busy,
	output logic                        agc_off,
	output logic                        out_bias_en,
	output logic                        lo_i,
	output logic                        lo_q
);
	logic [DCOCS_SER_W-1:0]  shift_r;
	logic [DCOCS_DIV_W-1:0]  cal_div_r;
	logic                    bias_r;
	logic                    trig_d_r;
	logic                    start;
	dcocs_state_t            state_r;
	logic [DCOCS_SLOT_W-1:0] slot_r;
	logic                    slot_tick;
	logic                    in_search;
	logic [DCOCS_DAC_W-1:0]  step_r;
	logic [DCOCS_DAC_W-1:0]  code_r [2];
	logic [1:0]              comp_pos;
	logic                    lo_i_r;
	logic                    lo_q_r;

	assign comp_pos = {q_comp_pos, i_comp_pos};

	// Serial port: MSB first, latch on load rise
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			shift_r <= '0;
		end else if (ser_clk_rise) begin
			shift_r <= {shift_r[DCOCS_SER_W-2:0], ser_data}; // [RQ17]
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cal_div_r <= DCOCS_DIV_RST;
			bias_r <= DCOCS_BIAS_RST;
		end else if (ser_load_rise && shift_r[DCOCS_ADDR_W-1:0] == DCOCS_ADDR_OFFCAL) begin
			cal_div_r <= shift_r[DCOCS_FLD_DIV_LSB +: DCOCS_DIV_W]; // [RQ16] [RQ17]
			bias_r <= shift_r[DCOCS_FLD_BIAS]; // [RQ13]
		end
	end

	assign out_bias_en = bias_r; // [RQ13]

	// Trigger edge detect
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			trig_d_r <= 1'b0;
		end else begin
			trig_d_r <= cal_trigger;
		end
	end

	assign start = cal_trigger && !trig_d_r; // [RQ3]

	dcocs_slot_timer u_timer (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.ref_tick  (ref_tick),
		.cal_div   (cal_div_r),
		.restart   (start),
		.slot_tick (slot_tick)
	);

	// Slot sequencer; mode inputs never block a start
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= DCOCS_IDLE;
			slot_r <= '0;
		end else if (start) begin
			state_r <= DCOCS_RUN; // [RQ3] [RQ12]
			slot_r <= 5'h01;
		end else if (state_r == DCOCS_RUN && slot_tick) begin
			slot_r <= slot_r + 5'h01;
			if (slot_r + 5'h01 == DCOCS_SLOT_HOLD) begin
				state_r <= DCOCS_DONE; // [RQ8]
			end
		end
	end

	assign cal_busy = (state_r == DCOCS_RUN);
	assign agc_off = cal_busy && rx_mode; // [RQ9]
	assign comp_balance = cal_busy && slot_r >= DCOCS_SLOT_BAL_FIRST
		&& slot_r <= DCOCS_SLOT_BAL_LAST; // [RQ5]
	assign in_search = cal_busy && slot_r >= DCOCS_SLOT_SRCH_FIRST
		&& slot_r <= DCOCS_SLOT_SRCH_LAST; // [RQ6]

	// Step size halves at each search slot end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			step_r <= '0;
		end else if (start) begin
			step_r <= {1'b0, DCOCS_DAC_MID[DCOCS_DAC_W-1:1]};
		end else if (in_search && slot_tick) begin
			step_r <= {1'b0, step_r[DCOCS_DAC_W-1:1]}; // [RQ7]
		end
	end

	// Per-channel SAR; slots 1-12 hold midscale, 22 freezes
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				code_r[ch] <= DCOCS_DAC_MID;
			end else if (start) begin
				code_r[ch] <= DCOCS_DAC_MID; // [RQ4] [RQ18]
			end else if (in_search && slot_tick && step_r != '0) begin
				if (comp_pos[ch]) begin // [RQ11]
					code_r[ch] <= code_r[ch] - step_r; // [RQ7]
				end else begin
					code_r[ch] <= code_r[ch] + step_r; // [RQ7]
				end
			end
		end
	end

	assign i_offset_current_dac = code_r[0]; // [RQ10]
	assign q_offset_current_dac = code_r[1];
	assign i_buf_dac = code_r[0][DCOCS_BUF_BITS-1:0]; // [RQ10]
	assign i_lpf_dac = code_r[0][DCOCS_DAC_W-1:DCOCS_BUF_BITS];
	assign q_buf_dac = code_r[1][DCOCS_BUF_BITS-1:0];
	assign q_lpf_dac = code_r[1][DCOCS_DAC_W-1:DCOCS_BUF_BITS];

	// LO quadrature from double-rate input, sampled synchronously
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lo_i_r <= 1'b0;
			lo_q_r <= 1'b0;
		end else if (double_rate_osc_input) begin
			lo_i_r <= ~lo_q_r; // [RQ14]
			lo_q_r <= lo_i_r;
		end
	end

	assign lo_i = lo_i_r;
	assign lo_q = lo_q_r;

	sequence s_start;
		$rose(cal_trigger);
	endsequence
	sequence s_run1;
		cal_busy && slot_r == 5'h01;
	endsequence

	sequence s_last_tick;
		cal_busy && slot_tick && slot_r == DCOCS_SLOT_SRCH_LAST && !start;
	endsequence
	sequence s_done;
		!cal_busy && state_r == DCOCS_DONE && slot_r == DCOCS_SLOT_HOLD;
	endsequence

	// Search decisions in this run, for end-of-run checks
	logic [3:0] srch_cnt_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			srch_cnt_r <= '0;
		end else if (start) begin
			srch_cnt_r <= '0;
		end else if (in_search && slot_tick) begin
			srch_cnt_r <= srch_cnt_r + 4'h1; // [RQ6]
		end
	end

	// Start handling
	trig_start_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ3]
		s_start |=> s_run1) else $error("no start on trigger edge");

	no_start_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ3]
		$rose(cal_busy) |-> $past(start)) else $error("start without edge");

	mode_free_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ12]
		start |=> cal_busy) else $error("start refused");

	// Settle, balance and gap slots
	settle_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ4]
		cal_busy && slot_r <= DCOCS_SLOT_SETTLE_END |-> !comp_balance && !in_search
		&& code_r[0] == DCOCS_DAC_MID) else $error("activity in settle");

	q_settle_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ4]
		cal_busy && slot_r <= DCOCS_SLOT_SETTLE_END |-> code_r[1] == DCOCS_DAC_MID) else $error("q moved");

	slot_range_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ4]
		cal_busy |-> slot_r >= 5'h01 && slot_r <= DCOCS_SLOT_SRCH_LAST) else $error("slot range");

	balance_win_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ5]
		comp_balance |-> slot_r >= 5'h08 && slot_r <= 5'h0A) else $error("balance slot");

	balance_on_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ5]
		cal_busy && slot_r >= 5'h08 && slot_r <= 5'h0A |-> comp_balance)
		else $error("balance missing");

	gap_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ18]
		cal_busy && (slot_r == 5'h0B || slot_r == 5'h0C) |=> $stable(code_r[0])
		&& $stable(code_r[1])) else $error("code moved in gap");

	// Search steps
	code_start_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ6]
		start |=> code_r[0] == DCOCS_DAC_MID && code_r[1] == DCOCS_DAC_MID
		&& step_r == (DCOCS_DAC_MID >> 1)) else $error("bad search start");

	step_halve_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ7]
		in_search && slot_tick |=> step_r == $past(step_r) >> 1) else $error("step");

	search_dir_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ11]
		in_search && slot_tick && step_r != '0 && i_comp_pos |=>
		code_r[0] < $past(code_r[0])) else $error("search direction");

	i_search_up_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ7]
		in_search && slot_tick && step_r != '0 && !i_comp_pos |=>
		code_r[0] > $past(code_r[0])) else $error("i search up");

	q_search_dn_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ11]
		in_search && slot_tick && step_r != '0 && q_comp_pos |=>
		code_r[1] < $past(code_r[1])) else $error("q search down");

	q_search_up_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ7]
		in_search && slot_tick && step_r != '0 && !q_comp_pos |=>
		code_r[1] > $past(code_r[1])) else $error("q search up");

	code_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ6]
		!(in_search && slot_tick) && !start |=> $stable(code_r[0])
		&& $stable(code_r[1])) else $error("code moved outside search");

	// Slot advance, end of run and AGC gating
	slot_step_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ2]
		cal_busy && slot_tick && !start |=> slot_r == $past(slot_r) + 5'h01) else $error("slot");

	slot_still_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ2]
		!slot_tick && !start |=> $stable(slot_r)) else $error("slot moved");

	run_end_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ8]
		s_last_tick |=> s_done) else $error("run did not end at hold slot");

	freeze_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ8]
		state_r == DCOCS_DONE && !start |=> $stable(code_r[0])
		&& $stable(code_r[1])) else $error("unfrozen");

	done_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ8]
		state_r == DCOCS_DONE |-> !cal_busy && !comp_balance && !in_search) else $error("done");

	done_count_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ6]
		state_r == DCOCS_DONE |->
		srch_cnt_r == 4'(DCOCS_SLOT_SRCH_LAST - DCOCS_SLOT_SRCH_FIRST + 5'h01)) else $error("steps");

	cnt_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ6]
		srch_cnt_r <= 4'(DCOCS_SLOT_SRCH_LAST - DCOCS_SLOT_SRCH_FIRST + 5'h01)) else $error("count");

	agc_mute_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ9]
		cal_busy && rx_mode |-> agc_off) else $error("agc on in cal");

	agc_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ9]
		!cal_busy |-> !agc_off) else $error("agc off while idle");

	// Settings and LO
	addr_miss_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ17]
		ser_load_rise && shift_r[DCOCS_ADDR_W-1:0] != DCOCS_ADDR_OFFCAL |=>
		$stable(cal_div_r) && $stable(out_bias_en)) else $error("wrong address loaded");

	bias_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ13]
		!ser_load_rise |=> $stable(out_bias_en) && $stable(cal_div_r)) else $error("bias moved");

	lo_quad_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ14]
		double_rate_osc_input |=> lo_i == !$past(lo_q) && lo_q == $past(lo_i)) else $error("lo");

	lo_still_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ14]
		!double_rate_osc_input |=> $stable(lo_i) && $stable(lo_q)) else $error("lo moved");

endmodule // dcocs_sequencer
`default_nettype wire

// >>> logic/dcocs_slot_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dcocs_slot_timer
	import dcocs_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	input  wire logic                   ref_tick,
	input  wire logic [DCOCS_DIV_W-1:0] cal_div,
	input  wire logic                   restart,
	output logic                        slot_tick
);
	logic [DCOCS_DIV_W-1:0] div_cnt_r;
	logic                   half_r;
	logic [DCOCS_DIV_W-1:0] div_eff;

	assign div_eff = (cal_div == '0) ? DCOCS_DIV_RST : cal_div;

	// Divide ref ticks by divider, then by two
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt_r <= '0;
			half_r <= 1'b0;
		end else if (restart) begin
			div_cnt_r <= '0;
			half_r <= 1'b0;
		end else if (ref_tick) begin
			if (div_cnt_r == div_eff - 7'h01) begin // [RQ1]
				div_cnt_r <= '0;
				half_r <= ~half_r; // [RQ2]
			end else begin
				div_cnt_r <= div_cnt_r + 7'h01;
			end
		end
	end

	assign slot_tick = !restart && ref_tick && half_r && (div_cnt_r == div_eff - 7'h01);

	slot_period_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RQ2]
		slot_tick |=> !slot_tick) else $error("slot tick repeated");
endmodule // dcocs_slot_timer
`default_nettype wire

// >>> test/dcocs_bb_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcocs_bb_model
	import dcocs_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	input  wire logic                   go,
	input  wire logic [DCOCS_DAC_W-1:0] i_code,
	input  wire logic [DCOCS_DAC_W-1:0] q_code,
	input  wire logic [DCOCS_DAC_W-1:0] i_target,
	input  wire logic [DCOCS_DAC_W-1:0] q_target,
	output logic                        cal_trigger,
	output logic                        i_comp_pos,
	output logic                        q_comp_pos
);
	logic pend_r;
	// Low for one cycle, then a fresh rising edge
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cal_trigger <= 1'b0;
			pend_r <= 1'b0;
		end else if (go) begin
			cal_trigger <= 1'b0;
			pend_r <= 1'b1;
		end else if (pend_r) begin
			cal_trigger <= 1'b1;
			pend_r <= 1'b0;
		end
	end
	// Offset still positive while code sits above the hidden zero point
	assign i_comp_pos = i_code > i_target;
	assign q_comp_pos = q_code > q_target;
endmodule // dcocs_bb_model
`default_nettype wire

// >>> test/dcocs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dcocs_sequencer_tb;
	import dcocs_pkg::*;
	logic sys_clk = 0, rstn = 0, ref_tick = 1, rx_mode = 0, sck = 0, sdat = 0, sle = 0;
	logic osc = 0, go = 0, trig, icp, qcp, bal, busy, agc, bias, loi, loq, b, li, lq;
	logic [7:0] ic, qc, it = 8'h00, qt = 8'h00;
	logic [4:0] il, ql;
	logic [2:0] ib, qb;
	int err_total = 0, cmp_count = 0, dv, n, nb, tg;
	localparam int RP = 2;
	always #2 sys_clk = ~sys_clk;
	// Reference tick every other clock
	always @(posedge sys_clk) ref_tick <= ~ref_tick;
	dcocs_bb_model bb (.sys_clk(sys_clk), .rstn(rstn), .go(go), .i_code(ic), .q_code(qc),
		.i_target(it), .q_target(qt), .cal_trigger(trig), .i_comp_pos(icp), .q_comp_pos(qcp));
	dcocs_sequencer dut (.sys_clk(sys_clk), .rstn(rstn), .ref_tick(ref_tick),
		.cal_trigger(trig), .rx_mode(rx_mode), .ser_clk_rise(sck), .ser_data(sdat),
		.ser_load_rise(sle), .i_comp_pos(icp), .q_comp_pos(qcp),
		.double_rate_osc_input(osc), .i_offset_current_dac(ic), .q_offset_current_dac(qc),
		.i_lpf_dac(il), .i_buf_dac(ib), .q_lpf_dac(ql), .q_buf_dac(qb), .comp_balance(bal),
		.cal_busy(busy), .agc_off(agc), .out_bias_en(bias), .lo_i(loi), .lo_q(loq));
	task chk(string nm, logic [7:0] s, logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask
	task wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	function logic [7:0] sar(logic [7:0] t);
		logic [7:0] c, s;
		c = 8'h80;
		s = 8'h40;
		for (int k = 0; k < 7; k++) begin
			c = (c > t) ? c - s : c + s;
			s = s >> 1;
		end
		return c;
	endfunction
	task ser(logic [6:0] d, logic bb_, logic [1:0] a);
		logic [19:0] w;
		w = {6'h00, bb_, 4'h0, d, a};
		for (int i = 19; i >= 0; i--) begin
			@(posedge sys_clk) sdat <= w[i];
			sck <= 1;
			@(posedge sys_clk) sck <= 0;
		end
		@(posedge sys_clk) sle <= 1;
		@(posedge sys_clk) sle <= 0;
		repeat (2) @(posedge sys_clk);
	endtask
	task cal(logic [7:0] ti, logic [7:0] tq, logic rs);
		@(posedge sys_clk);
		it <= ti;
		qt <= tq;
		rx_mode <= 1'($urandom);
		@(posedge sys_clk) go <= 1;
		@(posedge sys_clk) go <= 0;
		if (rs) begin
			repeat (20 * dv) @(posedge sys_clk);
			go <= 1;
			@(posedge sys_clk) go <= 0;
		end
		n = 0;
		nb = 0;
		tg = 0;
		repeat (4) @(posedge sys_clk);
		while (busy === 1'b1 && n < 2000) begin
			@(posedge sys_clk) osc <= ~osc;
			#1 n++;
			nb += int'(bal);
			chk("agc_off", agc, busy & rx_mode);
		end
		chk("busy_len", n >= 42 * RP * dv - 5 && n <= 42 * RP * dv + 2, 1);
		chk("bal_len", nb >= 6 * RP * dv - 1 && nb <= 6 * RP * dv + 1, 1);
		chk("i_code", ic, sar(ti));
		chk("q_code", qc, sar(tq));
		chk("i_split", {il, ib}, ic);
		chk("q_split", {ql, qb}, qc);
		@(posedge sys_clk) osc <= 0;
		it <= ~ti;
		qt <= ~tq;
		@(posedge sys_clk) #1;
		li = loi;
		lq = loq;
		repeat (8) begin
			@(posedge sys_clk) osc <= 1;
			@(posedge sys_clk) osc <= 0;
			#1 tg += int'(loi != li);
		end
		chk("lo_ret", {loi, loq}, {li, lq});
		chk("lo_tgl", tg > 0, 1);
		chk("hold_i", ic, sar(ti));
		chk("hold_q", qc, sar(tq));
		chk("hold_busy", busy, 0);
		$display("test cal %0d done", n);
	endtask
	initial begin
		void'($urandom(14));
		@(posedge sys_clk) #1;
		chk("dac_rst", ic, 8'h80);
		chk("bias_rst", bias, 0);
		@(posedge sys_clk) rstn <= 1;
		@(posedge sys_clk);
		dv = 3 + $urandom % 4;
		b = 1'($urandom);
		ser(7'(dv), b, 2'h3);
		chk("bias", bias, b);
		ser(7'h7F, ~b, 2'h2);
		chk("bias_addr", bias, b);
		$display("test serial done");
		for (int k = 0; k < 5; k++) cal(k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($urandom),
			8'($urandom), k == 4);
		wrap_up;
	end
	initial begin
		#100000;
		err_total++;
		wrap_up;
	end
endmodule // dcocs_sequencer_tb
`default_nettype wire
